// >>> common/frtc_pkg.sv
// Constants, register map and carrier types of the free-running timer counter.
// Assumes a single 100 MHz system clock and a plain strobe-based register port.
// Functional notes
// R1 - Counter advances once per timer clock, CPU clock divided by 2, 4 or 8.
// R2 - Two read-only byte pairs show the count; mirror low read keeps overflow flag.
// R3 - Any write to counter or mirror low byte forces the count to FFFCh.
// R4 - Reset loads FFFCh in every mode; it is the only reload value.
// R5 - Both clock select bits set picks the external count input.
// R6 - External mode counts only on the edge chosen by the polarity bit.
// R7 - External count updates are synchronised to the falling CPU clock edge; the code uses the rising clk_sys_i edge.
// R8 - External clock must allow four CPU falling edges between active edges.
// R9 - High byte read first captures the matching low byte into a buffer.
// R10 - Buffered low byte stays frozen until low read, despite repeated high reads.
// R11 - After a completed sequence, a lone low read returns the live low byte.
// R12 - Rollover from FFFFh to 0000h sets the overflow flag in every mode.
// R13 - Overflow interrupt needs its enable set and global mask clear; else pending.
// R14 - Flag clears after status read while set, then counter low access.
// R15 - Wait mode leaves the counter running.
// R16 - Halt stops the counter; interrupt wake resumes, reset wake restarts.
package frtc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] ADDR_COUNTER_HIGH = 4'h0;
  localparam logic [3:0] ADDR_COUNTER_LOW = 4'h1;
  localparam logic [3:0] ADDR_MIRROR_HIGH = 4'h2;
  localparam logic [3:0] ADDR_MIRROR_LOW = 4'h3;
  localparam logic [3:0] ADDR_FIRST_CTRL = 4'h4;
  localparam logic [3:0] ADDR_SECOND_CTRL = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h7;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h8;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h9;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int FIRST_CTRL_OVF_IE_BIT = 5;
  localparam int SECOND_CTRL_CC_LO = 2;
  localparam int SECOND_CTRL_EDGE_BIT = 0;
  localparam int STATUS_OVF_BIT = 5;
  localparam int IRQ_OVF_BIT = 0;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [15:0] COUNT_RESET = 16'hfffc;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [7:0] FIRST_CTRL_RESET = 8'h00;
  localparam logic [7:0] SECOND_CTRL_RESET = 8'h00;
  localparam logic [1:0] CC_DIV2 = 2'h0;
  localparam logic [1:0] CC_DIV4 = 2'h1;
  localparam logic [1:0] CC_DIV8 = 2'h2;
  localparam logic [1:0] CC_EXT = 2'h3;
  localparam logic [2:0] PRESC_W_MAX = 3'h7;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } frtc_bus_req_t;

  typedef enum logic [1:0] {
    FRTC_PWR_RUN,
    FRTC_PWR_WAIT,
    FRTC_PWR_HALT
  } frtc_pwr_t;

endpackage : frtc_pkg

// >>> rtl/frtc_top.sv
// Free-running 16-bit timer counter with prescaler, external clock and overflow flag.
// Assumes a processor on the same clock driving one-cycle read and write strobes.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module frtc_top
  import frtc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // Core and power
  input wire logic global_irq_mask_i,
  input wire logic halt_i,
  // External count pin
  input wire logic external_count_input_i,
  // Outputs to timer functions
  output logic [15:0] count_o,
  output logic timer_tick_o,
  output logic timer_irq_o,
  output logic irq_o
);

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire rst_n = rst_sync_ff;

  frtc_bus_req_t req;
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] first_control_reg_ff;
  logic [7:0] second_control_reg_ff;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      first_control_reg_ff <= FIRST_CTRL_RESET;
      second_control_reg_ff <= SECOND_CTRL_RESET;
    end else if (req.wr) begin
      if (req.addr == ADDR_FIRST_CTRL) begin
        first_control_reg_ff <= req.wdata;
      end
      if (req.addr == ADDR_SECOND_CTRL) begin
        second_control_reg_ff <= req.wdata;
      end
    end
  end
  wire overflow_irq_enable = first_control_reg_ff[FIRST_CTRL_OVF_IE_BIT];
  wire [1:0] clock_select_bits = second_control_reg_ff[SECOND_CTRL_CC_LO+:2];
  wire ext_edge_polarity = second_control_reg_ff[SECOND_CTRL_EDGE_BIT];

  // ****************************************
  // Prescaler
  // ****************************************
  logic [2:0] presc_ff;
  logic [2:0] presc_mask;
  always_comb begin
    case (clock_select_bits)
      CC_DIV2: presc_mask = 3'h1;
      CC_DIV4: presc_mask = 3'h3;
      CC_DIV8: presc_mask = PRESC_W_MAX;
      default: presc_mask = PRESC_W_MAX;
    endcase
  end
  // R16 prescaler held in halt
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      presc_ff <= 3'h0;
    end else if (!halt_i) begin
      presc_ff <= presc_ff + 3'h1;
    end
  end
  // R1 divide by 2, 4 or 8
  wire int_tick = ((presc_ff & presc_mask) == presc_mask) && !halt_i;

  // ****************************************
  // External count input
  // ****************************************
  logic ext_meta_ff;
  logic ext_sync_ff;
  logic ext_prev_ff;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else begin
      ext_meta_ff <= external_count_input_i;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
    end
  end
  // R6 edge chosen by polarity bit
  wire ext_edge = ext_edge_polarity ? (ext_sync_ff && !ext_prev_ff) : (!ext_sync_ff && ext_prev_ff);
  // R5 both select bits pick external
  wire use_ext = (clock_select_bits == CC_EXT);
  // R7 R8 synchronised to system clock; pin must be slow
  wire tick = use_ext ? (ext_edge && !halt_i) : int_tick;

  // ****************************************
  // Counter
  // ****************************************
  logic [15:0] count_ff;
  wire low_wr = req.wr && (req.addr == ADDR_COUNTER_LOW || req.addr == ADDR_MIRROR_LOW);
  wire rollover = tick && (count_ff == COUNT_MAX) && !low_wr;
  // R15 counts in wait, R16 holds in halt
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      // R4 reset count
      count_ff <= COUNT_RESET;
    end else if (low_wr) begin
      // R3 low write reloads
      count_ff <= COUNT_RESET;
    end else if (tick) begin
      // R1 advance
      count_ff <= count_ff + 16'h0001;
    end
  end
  assign count_o = count_ff;
  assign timer_tick_o = tick;

  // ****************************************
  // Latched 16-bit read
  // ****************************************
  logic [7:0] low_buf_ff;
  logic buf_valid_ff;
  wire hi_rd = req.rd && (req.addr == ADDR_COUNTER_HIGH || req.addr == ADDR_MIRROR_HIGH);
  wire lo_rd = req.rd && (req.addr == ADDR_COUNTER_LOW || req.addr == ADDR_MIRROR_LOW);
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      low_buf_ff <= 8'h00;
      buf_valid_ff <= 1'b0;
    end else if (hi_rd && !buf_valid_ff) begin
      // R9 capture low on high read
      low_buf_ff <= count_ff[7:0];
      buf_valid_ff <= 1'b1;
    end else if (lo_rd) begin
      // R11 sequence done
      buf_valid_ff <= 1'b0;
    end
  end

  // ****************************************
  // Overflow flag
  // ****************************************
  logic overflow_flag_ff;
  logic clr_armed_ff;
  wire sr_rd = req.rd && (req.addr == ADDR_STATUS);
  wire clr_access = (req.rd || req.wr) && (req.addr == ADDR_COUNTER_LOW);
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag_ff <= 1'b0;
      clr_armed_ff <= 1'b0;
    end else begin
      if (rollover) begin
        // R12 set on rollover, wins over clear
        overflow_flag_ff <= 1'b1;
      end else if (clr_armed_ff && clr_access) begin
        // R14 second step clears
        overflow_flag_ff <= 1'b0;
      end
      // R14 first step arms, R2 mirror never clears
      if (sr_rd && overflow_flag_ff) begin
        clr_armed_ff <= 1'b1;
      end else if (clr_access || !overflow_flag_ff) begin
        clr_armed_ff <= 1'b0;
      end
    end
  end
  // R13 pending until enable and mask allow
  assign timer_irq_o = overflow_flag_ff && overflow_irq_enable && !global_irq_mask_i;

  // ****************************************
  // Sticky event status
  // ****************************************
  logic irq_status_ff;
  logic irq_enable_ff;
  wire irq_clr = req.wr && (req.addr == ADDR_IRQ_CLEAR) && req.wdata[IRQ_OVF_BIT];
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_ff <= 1'b0;
      irq_enable_ff <= 1'b0;
    end else begin
      if (rollover) begin
        irq_status_ff <= 1'b1;
      end else if (irq_clr) begin
        irq_status_ff <= 1'b0;
      end
      if (req.wr && req.addr == ADDR_IRQ_ENABLE) begin
        irq_enable_ff <= req.wdata[IRQ_OVF_BIT];
      end
    end
  end
  assign irq_o = irq_status_ff && irq_enable_ff;

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;
  always_comb begin
    nxt_rdata = 8'h00;
    case (req.addr)
      // R2 both views show the count
      ADDR_COUNTER_HIGH: nxt_rdata = count_ff[15:8];
      ADDR_MIRROR_HIGH: nxt_rdata = count_ff[15:8];
      // R10 frozen buffer until low read
      ADDR_COUNTER_LOW: nxt_rdata = buf_valid_ff ? low_buf_ff : count_ff[7:0];
      ADDR_MIRROR_LOW: nxt_rdata = buf_valid_ff ? low_buf_ff : count_ff[7:0];
      ADDR_FIRST_CTRL: nxt_rdata = first_control_reg_ff;
      ADDR_SECOND_CTRL: nxt_rdata = second_control_reg_ff;
      ADDR_STATUS: nxt_rdata = 8'(overflow_flag_ff) << STATUS_OVF_BIT;
      ADDR_IRQ_STATUS: nxt_rdata = 8'(irq_status_ff) << IRQ_OVF_BIT;
      ADDR_IRQ_ENABLE: nxt_rdata = 8'(irq_enable_ff) << IRQ_OVF_BIT;
      default: nxt_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (req.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  assign reg_rdata_o = rdata_ff;

endmodule : frtc_top

// >>> testbench/frtc_ext_src.sv
// External count source for the count pin.
// Toggles every half_i clocks while en_i is high.
`timescale 1ns/10ps
module frtc_ext_src (
  // Control
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [3:0] half_i,
  // Pin
  output logic pin_o
);
  logic [3:0] cnt_ff = 4'h0;
  initial pin_o = 1'b0;
  always @(posedge clk_i) begin
    if (!en_i || cnt_ff + 4'h1 >= half_i) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
    if (en_i && cnt_ff + 4'h1 >= half_i) begin
      pin_o <= !pin_o;
    end
  end
endmodule : frtc_ext_src

// >>> testbench/frtc_top_assertions.sv
// Port checker for the timer counter.
// Bound to frtc_top; sees only its ports.
`timescale 1ns/10ps
module frtc_top_assertions
  import frtc_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // Core, power and outputs
  input wire logic global_irq_mask_i,
  input wire logic halt_i,
  input wire logic [15:0] count_o,
  input wire logic timer_tick_o,
  input wire logic timer_irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic wr_lo;
  assign wr_lo = reg_wr_i && (reg_addr_i == ADDR_COUNTER_LOW || reg_addr_i == ADDR_MIRROR_LOW);
  property p_inc;
    timer_tick_o && !wr_lo |=> count_o == $past(count_o) + 16'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("count not advanced");
  property p_hold;
    !timer_tick_o && !wr_lo |=> $stable(count_o);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  property p_load;
    wr_lo |=> count_o == COUNT_RESET;
  endproperty
  a_load: assert property (p_load) else $error("no reload");
  property p_halt;
    halt_i |-> !timer_tick_o;
  endproperty
  a_halt: assert property (p_halt) else $error("tick in halt");
  property p_gap;
    timer_tick_o |=> !timer_tick_o;
  endproperty
  a_gap: assert property (p_gap) else $error("ticks too close");
  property p_high;
    reg_rd_i && reg_addr_i[0] == 1'b0 && reg_addr_i < 4'h4 |=> reg_rdata_o == $past(count_o[15:8]);
  endproperty
  a_high: assert property (p_high) else $error("bad high byte");
  property p_mask;
    global_irq_mask_i |-> !timer_irq_o;
  endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_idle;
    !reg_rd_i |=> reg_rdata_o == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data lingers");
endmodule : frtc_top_assertions
bind frtc_top frtc_top_assertions u_chk (.clk_sys_i, .reset_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .global_irq_mask_i, .halt_i, .count_o, .timer_tick_o, .timer_irq_o);

// >>> testbench/tb.sv
// Self-checking bench of the timer counter.
// Drives the register port and an external count source.
`timescale 1ns/10ps
module tb;
  import frtc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] half = 4'h3;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [7:0] lo_exp;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic mask = 1'b0;
  logic halt = 1'b0;
  logic en = 1'b0;
  logic pin, tick, tirq, irq;
  logic [15:0] cnt, snap;
  int num_errors = 0;
  int n_checks = 0;
  int c;
  always #5 clk_sys_i = !clk_sys_i;
  frtc_top dut (.clk_sys_i, .reset_n_i, .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .global_irq_mask_i(mask), .halt_i(halt),
    .external_count_input_i(pin), .count_o(cnt), .timer_tick_o(tick), .timer_irq_o(tirq), .irq_o(irq));
  frtc_ext_src u_src (.clk_i(clk_sys_i), .en_i(en), .half_i(half), .pin_o(pin));
  task automatic results;
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    #1 snap = cnt;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic tk(output int n);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
    end while (tick !== 1'b1 && n < 300);
    if (n >= 300) begin
      chk(16'h0, 16'h1, "tick timeout");
      results();
    end
  endtask : tk
  initial begin
    void'($urandom(32'h0425));
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk(cnt, COUNT_RESET, "reset count");
    rd_reg(ADDR_SECOND_CTRL, d);
    chk(d, SECOND_CTRL_RESET, "ctrl reset");
    rd_reg(4'hf, d);
    chk(d, 8'h00, "unmapped");
    for (int k = 0; k < 3; k++) begin
      wr_reg(ADDR_SECOND_CTRL, {4'h0, 2'(k), 2'h0});
      tk(c);
      tk(c);
      chk(16'(c), 16'h2 << k, "prescale");
    end
    for (int k = 0; k < 2; k++) begin
      half = 4'(3 + $urandom % 6);
      wr_reg(ADDR_SECOND_CTRL, {4'h0, CC_EXT, 1'b0, 1'(k)});
      en <= 1'b1;
      tk(c);
      tk(c);
      chk(16'(c), {11'h0, half, 1'b0}, "external edge");
      chk(16'(pin), 16'(k), "edge polarity");
      en <= 1'b0;
    end
    wr_reg(ADDR_SECOND_CTRL, 8'h00);
    rd_reg(ADDR_COUNTER_HIGH, d);
    chk(d, snap[15:8], "high byte");
    lo_exp = snap[7:0];
    repeat (20) @(posedge clk_sys_i);
    rd_reg(ADDR_COUNTER_HIGH, d);
    rd_reg(ADDR_COUNTER_LOW, d);
    chk(d, lo_exp, "buffered low");
    rd_reg(ADDR_MIRROR_LOW, d);
    chk(d, snap[7:0], "live low");
    wr_reg(ADDR_FIRST_CTRL, 8'h20);
    wr_reg(ADDR_IRQ_ENABLE, 8'h01);
    wr_reg(ADDR_MIRROR_LOW, 8'($urandom));
    chk(cnt, COUNT_RESET, "reload");
    repeat (12) @(posedge clk_sys_i);
    #1 chk({tirq, irq}, 16'h3, "overflow irq");
    mask <= 1'b1;
    @(posedge clk_sys_i);
    #1 chk(tirq, 16'h0, "masked");
    mask <= 1'b0;
    @(posedge clk_sys_i);
    #1 chk(tirq, 16'h1, "pending");
    rd_reg(ADDR_STATUS, d);
    rd_reg(ADDR_MIRROR_LOW, d);
    rd_reg(ADDR_STATUS, d);
    chk(d[5], 16'h1, "flag kept");
    rd_reg(ADDR_COUNTER_LOW, d);
    rd_reg(ADDR_STATUS, d);
    chk({d[5], tirq}, 16'h0, "flag cleared");
    rd_reg(ADDR_IRQ_STATUS, d);
    chk(d, 8'h01, "sticky");
    wr_reg(ADDR_IRQ_CLEAR, 8'h01);
    chk(irq, 16'h0, "irq clear");
    halt <= 1'b1;
    @(posedge clk_sys_i);
    #1 snap = cnt;
    repeat (20) @(posedge clk_sys_i);
    #1 chk(cnt, snap, "halt hold");
    halt <= 1'b0;
    tk(c);
    @(posedge clk_sys_i);
    #1 chk(cnt, snap + 16'h1, "resume");
    reset_n_i <= 1'b0;
    @(posedge clk_sys_i);
    #1 chk(cnt, COUNT_RESET, "second reset");
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd_reg(ADDR_FIRST_CTRL, d);
    chk(d, FIRST_CTRL_RESET, "ctrl after reset");
    results();
  end
endmodule : tb
